/* File: hdl/fsq_pkg.sv */
`default_nettype none
package fsq_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int unsigned CLK_MHZ        = 40;
	localparam int unsigned ERASE_WIN_US   = 80;
	localparam int unsigned ERASE_WIN_CYC  = ERASE_WIN_US * CLK_MHZ;
	localparam int unsigned CMD_GAP_US     = 100;
	localparam int unsigned CMD_GAP_CYC    = CMD_GAP_US * CLK_MHZ;
	localparam int unsigned PROG_CYC_DEF   = 400;
	localparam int unsigned SETTLE_CYC_DEF = 40;
	localparam int unsigned TMR_W          = 12;

	// ----------------------------------------
	// array geometry
	// ----------------------------------------
	localparam int unsigned NSECT       = 12;
	localparam int unsigned IDX_W       = 19;
	localparam int unsigned STORE_DEPTH = 327680;
	localparam logic [18:0] SEC_BASE    = 19'h40000;
	localparam logic [14:0] PRI_LAST    = 15'h7FFF;
	localparam logic [14:0] SEC_LAST    = 15'h3FFF;
	localparam logic [11:0] PRI_MASK    = 12'h0FF;
	localparam logic [11:0] SEC_MASK    = 12'hF00;
	localparam logic [3:0]  WALK_END    = 4'hC;
	localparam logic [7:0]  ERASED_BYTE = 8'hFF;

	// ----------------------------------------
	// command bytes and decode addresses
	// ----------------------------------------
	localparam logic [7:0]  CMD_UNLOCK1 = 8'hAA;
	localparam logic [7:0]  CMD_UNLOCK2 = 8'h55;
	localparam logic [7:0]  CMD_AUTOSEL = 8'h90;
	localparam logic [7:0]  CMD_PROG    = 8'hA0;
	localparam logic [7:0]  CMD_ERASE   = 8'h80;
	localparam logic [7:0]  CMD_SECTOR  = 8'h30;
	localparam logic [7:0]  CMD_BULK    = 8'h10;
	localparam logic [7:0]  CMD_SUSPEND = 8'hB0;
	localparam logic [7:0]  CMD_RESET   = 8'hF0;
	localparam logic [7:0]  CMD_BYPASS  = 8'h20;
	localparam logic [7:0]  CMD_BYP_EXIT = 8'h00;
	localparam logic [11:0] UNLOCK_A    = 12'h555;
	localparam logic [11:0] UNLOCK_B    = 12'hAAA;
	localparam logic [2:0]  ID_SEL      = 3'h1;
	localparam logic [2:0]  PROT_SEL    = 3'h2;

	// ----------------------------------------
	// status byte layout
	// ----------------------------------------
	localparam int unsigned POLL_BIT   = 7;
	localparam int unsigned TOGGLE_BIT = 6;
	localparam int unsigned ERROR_BIT  = 5;
	localparam int unsigned WIN_BIT    = 3;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  data;
		logic        rd_n;
		logic        wr_n;
	} fsq_bus_t;

	typedef struct packed {
		logic [3:0] secondary;
		logic [7:0] primary;
	} fsq_sel_t;

	typedef struct packed {
		logic        wr_en;
		logic [18:0] idx;
		logic [7:0]  data;
	} fsq_wr_t;

	localparam fsq_bus_t BUS_IDLE = '{16'h0000, 8'h00, 1'b1, 1'b1};

	typedef enum logic [9:0] {
		C_IDLE = 10'h001,
		C_U1   = 10'h002,
		C_U2   = 10'h004,
		C_ID   = 10'h008,
		C_PGM  = 10'h010,
		C_E1   = 10'h020,
		C_E2   = 10'h040,
		C_E3   = 10'h080,
		C_BPGM = 10'h100,
		C_BRST = 10'h200
	} fsq_cmd_t;

	typedef enum logic [4:0] {
		O_IDLE  = 5'h01,
		O_PROG  = 5'h02,
		O_EWIN  = 5'h04,
		O_ERASE = 5'h08,
		O_SUSP  = 5'h10
	} fsq_op_t;

endpackage

`default_nettype wire

/* File: hdl/fsq_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none

// How it works
// - primary bank: eight 32 Kbyte sectors, each with an active-high select
// - secondary bank: four 16 Kbyte sectors, each with an active-high select
// - per-sector protection; protected sectors are never programmed or erased
// - ready/busy low during program or erase, high otherwise
// - plain bus writes never alter stored bytes
// - read mode returns stored byte on a single read
// - commands start AAh at 555h, 55h at AAAh, command at 555h
// - after 90h, primary bank read with A6,A1,A0 = 0,0,1 returns primary identifier; secondary returns 00h
// - after 90h, A6,A1,A0 = 0,1,0 returns 01h protected, 00h not
// - program address taken at strobe fall, data at strobe rise
// - erase: unlock, 80h, unlock, then 30h per sector or 10h bank
// - extra 30h sector adds accepted within 80 us of previous
// - B0h suspends sector erase; ignored otherwise
// - while suspended: reads, programs outside erasing sectors, identifier reads
// - 30h resumes erase only while suspended
// - F0h returns to read mode after identifier reads
// - unlock then 20h enters bypass; A0h plus data programs a byte
// - bypass: 90h then 00h leaves bypass mode
// - decode looks only at A11..A0
// - command cycles count only while a select of the bank is high
// - bad sequence or long gap aborts to read mode
// - primary selects route to primary bank, secondary to secondary
// - command logic starts in read mode after reset
// - busy reads toggle bit 6 each read; stops when done
module fsq_sequencer #(
	parameter int unsigned PROG_CYCLES   = fsq_pkg::PROG_CYC_DEF,
	parameter int unsigned SETTLE_CYCLES = fsq_pkg::SETTLE_CYC_DEF,
	// arbitrary identifier value
	parameter logic [7:0]  PRIMARY_ID    = 8'h5A
) (
	input  wire logic              i_clock,
	input  wire logic              i_rst_n,
	input  wire logic              i_clk_en,
	input  wire fsq_pkg::fsq_bus_t i_bus,
	input  wire fsq_pkg::fsq_sel_t i_sel,
	input  wire logic [11:0]       i_protect,
	output logic [7:0]             o_data,
	output logic                   o_data_oe,
	output logic                   o_ready_busy
);

	localparam int unsigned W = fsq_pkg::TMR_W;

	fsq_pkg::fsq_bus_t bus_s1_reg;
	fsq_pkg::fsq_bus_t bus_s2_reg;
	fsq_pkg::fsq_sel_t sel_s1_reg;
	fsq_pkg::fsq_sel_t sel_s2_reg;
	fsq_pkg::fsq_cmd_t cmd_reg;
	fsq_pkg::fsq_cmd_t cmd_next;
	fsq_pkg::fsq_op_t  op_reg;
	fsq_pkg::fsq_wr_t  store_wr;
	logic              wr_d_reg;
	logic              rd_d_reg;
	logic              wr_ok_reg;
	logic              rd_take_reg;
	logic [15:0]       wr_addr_reg;
	logic [3:0]        wr_sec_reg;
	logic [3:0]        rd_sec_reg;
	logic [2:0]        rd_asel_reg;
	logic              byp_reg;
	logic              susp_reg;
	logic              tog_reg;
	logic              prog_bank_reg;
	logic              ers_bank_reg;
	logic              bulk_reg;
	logic [11:0]       mask_reg;
	logic [3:0]        ers_sec_reg;
	logic [14:0]       ers_off_reg;
	logic [18:0]       prog_idx_reg;
	logic [7:0]        prog_byte_reg;
	logic [W-1:0]      tmr_reg;
	logic [W-1:0]      gap_reg;
	logic              wr_rise;
	logic              rd_fall;
	logic [11:0]       sel_now;
	logic [11:0]       wa;
	logic [7:0]        wd;
	logic [7:0]        store_q;
	logic [7:0]        status;
	logic [7:0]        id_byte;
	logic              busy;
	logic              busy_bank;
	logic              walk_end;
	logic              prog_ok;
	logic              prog_end;
	logic              win_out;
	logic              ers_done;
	logic              gap_out;
	logic              go_prog;
	logic              ers_add;
	logic              go_bulk;
	logic              go_susp;
	logic              go_resume;
	logic              byp_set;
	logic              byp_clr;

	// ----------------------------------------
	// sector decode
	// ----------------------------------------
	// lowest active select wins if the decoder overlaps
	function automatic logic [3:0] sec_of(input logic [11:0] s);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 11; i >= 0; i--) begin
			if (s[i])
				n = 4'(i);
		end
		return n;
	endfunction

	function automatic logic [18:0] idx_of(input logic [3:0] sec, input logic [15:0] a);
		if (sec[3])
			return fsq_pkg::SEC_BASE | {3'h0, sec[1:0], a[13:0]};
		return {1'b0, sec[2:0], a[14:0]};
	endfunction

	assign sel_now  = {sel_s2_reg.secondary, sel_s2_reg.primary};
	assign wr_rise  = ~wr_d_reg & bus_s2_reg.wr_n & wr_ok_reg;
	assign rd_fall  = rd_d_reg & ~bus_s2_reg.rd_n;
	assign wa       = wr_addr_reg[11:0];
	assign wd       = bus_s2_reg.data;
	assign busy     = op_reg inside {fsq_pkg::O_PROG, fsq_pkg::O_EWIN, fsq_pkg::O_ERASE};
	assign walk_end = ers_sec_reg == fsq_pkg::WALK_END;

	// ----------------------------------------
	// pin synchronisers and strobe edges
	// ----------------------------------------
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bus_s1_reg <= fsq_pkg::BUS_IDLE;
			bus_s2_reg <= fsq_pkg::BUS_IDLE;
			sel_s1_reg <= '0;
			sel_s2_reg <= '0;
		end else if (i_clk_en) begin
			bus_s1_reg <= i_bus;
			bus_s2_reg <= bus_s1_reg;
			sel_s1_reg <= i_sel;
			sel_s2_reg <= sel_s1_reg;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_d_reg    <= 1'b1;
			rd_d_reg    <= 1'b1;
			wr_ok_reg   <= 1'b0;
			wr_addr_reg <= '0;
			wr_sec_reg  <= '0;
			rd_take_reg <= 1'b0;
			rd_sec_reg  <= '0;
			rd_asel_reg <= '0;
		end else if (i_clk_en) begin
			wr_d_reg    <= bus_s2_reg.wr_n;
			rd_d_reg    <= bus_s2_reg.rd_n;
			rd_take_reg <= rd_fall & (|sel_now);
			if (wr_d_reg & ~bus_s2_reg.wr_n) begin
				wr_addr_reg <= bus_s2_reg.addr;
				wr_sec_reg  <= sec_of(sel_now);
				wr_ok_reg   <= |sel_now;
			end
			if (rd_fall) begin
				rd_sec_reg  <= sec_of(sel_now);
				rd_asel_reg <= {bus_s2_reg.addr[6], bus_s2_reg.addr[1:0]};
			end
		end
	end

	// ----------------------------------------
	// command decoder
	// ----------------------------------------
	assign prog_ok = ~i_protect[wr_sec_reg]
		& ~(susp_reg & mask_reg[wr_sec_reg])
		& (op_reg inside {fsq_pkg::O_IDLE, fsq_pkg::O_SUSP});

	always_comb begin
		cmd_next  = cmd_reg;
		go_prog   = 1'b0;
		ers_add   = 1'b0;
		go_bulk   = 1'b0;
		go_susp   = 1'b0;
		go_resume = 1'b0;
		byp_set   = 1'b0;
		byp_clr   = 1'b0;
		if (gap_out)
			cmd_next = fsq_pkg::C_IDLE;
		if (wr_rise) begin
			unique case (cmd_reg)
				fsq_pkg::C_IDLE: begin
					if (op_reg == fsq_pkg::O_ERASE || op_reg == fsq_pkg::O_EWIN) begin
						if (wd == fsq_pkg::CMD_SUSPEND)
							go_susp = ~bulk_reg;
						else if (op_reg == fsq_pkg::O_EWIN && wd == fsq_pkg::CMD_SECTOR)
							ers_add = ~i_protect[wr_sec_reg];
					end else if (op_reg == fsq_pkg::O_SUSP && wd == fsq_pkg::CMD_SECTOR) begin
						go_resume = 1'b1;
					end else if (op_reg == fsq_pkg::O_PROG) begin
						cmd_next = fsq_pkg::C_IDLE;
					end else if (byp_reg) begin
						if (wd == fsq_pkg::CMD_PROG)
							cmd_next = fsq_pkg::C_BPGM;
						else if (wd == fsq_pkg::CMD_AUTOSEL)
							cmd_next = fsq_pkg::C_BRST;
					end else if (wd == fsq_pkg::CMD_UNLOCK1 && wa == fsq_pkg::UNLOCK_A) begin
						cmd_next = fsq_pkg::C_U1;
					end
				end
				fsq_pkg::C_U1, fsq_pkg::C_E2: begin
					cmd_next = fsq_pkg::C_IDLE;
					if (wd == fsq_pkg::CMD_UNLOCK2 && wa == fsq_pkg::UNLOCK_B)
						cmd_next = (cmd_reg == fsq_pkg::C_U1) ? fsq_pkg::C_U2 : fsq_pkg::C_E3;
				end
				fsq_pkg::C_U2: begin
					cmd_next = fsq_pkg::C_IDLE;
					if (wa == fsq_pkg::UNLOCK_A) begin
						if (wd == fsq_pkg::CMD_AUTOSEL)
							cmd_next = fsq_pkg::C_ID;
						else if (wd == fsq_pkg::CMD_PROG)
							cmd_next = fsq_pkg::C_PGM;
						else if (wd == fsq_pkg::CMD_ERASE && op_reg == fsq_pkg::O_IDLE)
							cmd_next = fsq_pkg::C_E1;
						else if (wd == fsq_pkg::CMD_BYPASS && op_reg == fsq_pkg::O_IDLE)
							byp_set = 1'b1;
					end
				end
				fsq_pkg::C_ID: begin
					if (wd == fsq_pkg::CMD_RESET)
						cmd_next = fsq_pkg::C_IDLE;
				end
				fsq_pkg::C_PGM, fsq_pkg::C_BPGM: begin
					cmd_next = fsq_pkg::C_IDLE;
					go_prog  = prog_ok;
				end
				fsq_pkg::C_E1: begin
					cmd_next = fsq_pkg::C_IDLE;
					if (wd == fsq_pkg::CMD_UNLOCK1 && wa == fsq_pkg::UNLOCK_A)
						cmd_next = fsq_pkg::C_E2;
				end
				fsq_pkg::C_E3: begin
					cmd_next = fsq_pkg::C_IDLE;
					if (wd == fsq_pkg::CMD_SECTOR)
						ers_add = ~i_protect[wr_sec_reg];
					else if (wd == fsq_pkg::CMD_BULK && wa == fsq_pkg::UNLOCK_A)
						go_bulk = 1'b1;
				end
				fsq_pkg::C_BRST: begin
					cmd_next = fsq_pkg::C_IDLE;
					byp_clr  = wd == fsq_pkg::CMD_BYP_EXIT;
				end
				default: cmd_next = fsq_pkg::C_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cmd_reg <= fsq_pkg::C_IDLE;
			byp_reg <= 1'b0;
		end else if (i_clk_en) begin
			cmd_reg <= cmd_next;
			if (byp_set)
				byp_reg <= 1'b1;
			else if (byp_clr)
				byp_reg <= 1'b0;
		end
	end

	// an idle host between unlock bytes must not leave a half-open command armed
	assign gap_out = gap_reg == W'(fsq_pkg::CMD_GAP_CYC - 1);

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n)
			gap_reg <= '0;
		else if (i_clk_en) begin
			if (wr_rise || cmd_reg inside {fsq_pkg::C_IDLE, fsq_pkg::C_ID})
				gap_reg <= '0;
			else
				gap_reg <= gap_reg + 1'b1;
		end
	end

	// ----------------------------------------
	// embedded operation sequencer
	// ----------------------------------------
	assign prog_end = op_reg == fsq_pkg::O_PROG && tmr_reg == W'(PROG_CYCLES - 1);
	assign win_out  = op_reg == fsq_pkg::O_EWIN && !ers_add
		&& tmr_reg == W'(fsq_pkg::ERASE_WIN_CYC - 1);
	assign ers_done = op_reg == fsq_pkg::O_ERASE && walk_end
		&& tmr_reg == W'(SETTLE_CYCLES - 1);

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			op_reg   <= fsq_pkg::O_IDLE;
			susp_reg <= 1'b0;
		end else if (i_clk_en) begin
			if (go_susp)
				susp_reg <= 1'b1;
			else if (go_resume)
				susp_reg <= 1'b0;
			unique case (op_reg)
				fsq_pkg::O_IDLE: begin
					if (go_prog)
						op_reg <= fsq_pkg::O_PROG;
					else if (ers_add)
						op_reg <= fsq_pkg::O_EWIN;
					else if (go_bulk)
						op_reg <= fsq_pkg::O_ERASE;
				end
				fsq_pkg::O_PROG: begin
					if (prog_end)
						op_reg <= susp_reg ? fsq_pkg::O_SUSP : fsq_pkg::O_IDLE;
				end
				fsq_pkg::O_EWIN, fsq_pkg::O_ERASE: begin
					if (go_susp)
						op_reg <= fsq_pkg::O_SUSP;
					else if (win_out)
						op_reg <= fsq_pkg::O_ERASE;
					else if (ers_done)
						op_reg <= fsq_pkg::O_IDLE;
				end
				fsq_pkg::O_SUSP: begin
					if (go_prog)
						op_reg <= fsq_pkg::O_PROG;
					else if (go_resume)
						op_reg <= fsq_pkg::O_ERASE;
				end
				default: op_reg <= fsq_pkg::O_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n)
			tmr_reg <= '0;
		else if (i_clk_en) begin
			if (go_prog || ers_add || go_bulk || go_susp || go_resume || prog_end || win_out)
				tmr_reg <= '0;
			else if (op_reg inside {fsq_pkg::O_PROG, fsq_pkg::O_EWIN}
				|| (op_reg == fsq_pkg::O_ERASE && walk_end))
				tmr_reg <= tmr_reg + 1'b1;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			prog_idx_reg  <= '0;
			prog_byte_reg <= '0;
			prog_bank_reg <= 1'b0;
		end else if (i_clk_en && go_prog) begin
			prog_idx_reg  <= idx_of(wr_sec_reg, wr_addr_reg);
			prog_byte_reg <= wd;
			prog_bank_reg <= wr_sec_reg[3];
		end
	end

	// erase walks each marked sector byte by byte, so the walk plus the settle count is the erase time
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mask_reg     <= '0;
			ers_sec_reg  <= '0;
			ers_off_reg  <= '0;
			ers_bank_reg <= 1'b0;
			bulk_reg     <= 1'b0;
		end else if (i_clk_en) begin
			if (ers_add || go_bulk) begin
				ers_sec_reg <= '0;
				ers_off_reg <= '0;
				// a bank erase is not a sector erase, so it cannot be suspended
				bulk_reg    <= go_bulk;
				if (op_reg == fsq_pkg::O_IDLE)
					ers_bank_reg <= wr_sec_reg[3];
			end
			if (ers_add)
				mask_reg <= mask_reg | (12'h001 << wr_sec_reg);
			else if (go_bulk)
				mask_reg <= (wr_sec_reg[3] ? fsq_pkg::SEC_MASK : fsq_pkg::PRI_MASK)
					& ~i_protect;
			else if (op_reg == fsq_pkg::O_ERASE && !walk_end) begin
				if (!mask_reg[ers_sec_reg])
					ers_sec_reg <= ers_sec_reg + 1'b1;
				else if (ers_off_reg == (ers_sec_reg[3] ? fsq_pkg::SEC_LAST : fsq_pkg::PRI_LAST)) begin
					mask_reg[ers_sec_reg] <= 1'b0;
					ers_sec_reg           <= ers_sec_reg + 1'b1;
					ers_off_reg           <= '0;
				end else
					ers_off_reg <= ers_off_reg + 1'b1;
			end
		end
	end

	// ----------------------------------------
	// array access
	// ----------------------------------------
	// only the sequencer writes the array; bus writes are consumed as commands
	always_comb begin
		store_wr = '0;
		if (prog_end) begin
			store_wr.wr_en = 1'b1;
			store_wr.idx   = prog_idx_reg;
			store_wr.data  = prog_byte_reg;
		end else if (op_reg == fsq_pkg::O_ERASE && !walk_end && mask_reg[ers_sec_reg]) begin
			store_wr.wr_en = 1'b1;
			store_wr.idx   = idx_of(ers_sec_reg, {1'b0, ers_off_reg});
			store_wr.data  = fsq_pkg::ERASED_BYTE;
		end
	end

	fsq_store u_store (
		.i_clock   (i_clock),
		.i_clk_en  (i_clk_en),
		.i_wr      (store_wr),
		.i_rd_idx  (idx_of(sec_of(sel_now), bus_s2_reg.addr)),
		.o_rd_data (store_q)
	);

	// ----------------------------------------
	// read data and status
	// ----------------------------------------
	assign busy_bank = (op_reg == fsq_pkg::O_PROG) ? prog_bank_reg : ers_bank_reg;

	always_comb begin
		status                      = 8'h00;
		status[fsq_pkg::POLL_BIT]   = (op_reg == fsq_pkg::O_PROG) & ~prog_byte_reg[7];
		status[fsq_pkg::TOGGLE_BIT] = ~tog_reg;
		status[fsq_pkg::ERROR_BIT]  = 1'b0;
		status[fsq_pkg::WIN_BIT]    = op_reg == fsq_pkg::O_ERASE;
		id_byte                     = 8'h00;
		if (rd_asel_reg == fsq_pkg::ID_SEL && !rd_sec_reg[3])
			id_byte = PRIMARY_ID;
		else if (rd_asel_reg == fsq_pkg::PROT_SEL)
			id_byte = {7'h00, i_protect[rd_sec_reg]};
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_data    <= 8'h00;
			o_data_oe <= 1'b0;
			tog_reg   <= 1'b0;
		end else if (i_clk_en) begin
			o_data_oe <= ~bus_s2_reg.rd_n & (|sel_now);
			if (rd_take_reg) begin
				if (busy && rd_sec_reg[3] == busy_bank) begin
					o_data  <= status;
					tog_reg <= ~tog_reg;
				end else if (cmd_reg == fsq_pkg::C_ID)
					o_data <= id_byte;
				else
					o_data <= store_q;
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n)
			o_ready_busy <= 1'b1;
		else if (i_clk_en)
			o_ready_busy <= ~(busy | go_prog | ers_add | go_bulk | go_resume);
	end

endmodule

`default_nettype wire

/* File: hdl/fsq_store.sv */
`timescale 1ns/1ps
`default_nettype none

module fsq_store (
	input  wire logic                         i_clock,
	input  wire logic                         i_clk_en,
	input  wire fsq_pkg::fsq_wr_t             i_wr,
	input  wire logic [fsq_pkg::IDX_W-1:0]    i_rd_idx,
	output logic [7:0]                        o_rd_data
);

	logic [7:0] mem [fsq_pkg::STORE_DEPTH];

	// blank array starts erased
	initial begin
		for (int i = 0; i < fsq_pkg::STORE_DEPTH; i++) begin
			mem[i] = fsq_pkg::ERASED_BYTE;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_clk_en) begin
			if (i_wr.wr_en)
				mem[i_wr.idx] <= i_wr.data;
			o_rd_data <= mem[i_rd_idx];
		end
	end

endmodule

`default_nettype wire

/* File: verif/dual_bank_flash_command_sequencer_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin error_cnt++; \
	$display("Error %s expected %h seen %h", n, e, s); end end

module dual_bank_flash_command_sequencer_test;
	// arbitrary identifier value
	localparam logic [7:0] ID = 8'hC3;
	logic              i_clock = 1'b0;
	logic              i_rst_n = 1'b0;
	logic              i_clk_en = 1'b1;
	logic [11:0]       prot = 12'h004;
	fsq_pkg::fsq_bus_t bus;
	fsq_pkg::fsq_sel_t sel;
	logic [7:0]        q;
	logic [7:0]        q2;
	logic [7:0]        rd_q;
	logic              rb;
	logic              oe;
	int                error_cnt = 0;
	int                tests_run = 0;
	fsq_mcu mcu (.i_clock(i_clock), .i_data(q), .o_bus(bus), .o_sel(sel));
	fsq_sequencer #(.PROG_CYCLES(80), .SETTLE_CYCLES(4), .PRIMARY_ID(ID)) dut (
		.i_clock(i_clock), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en), .i_bus(bus),
		.i_sel(sel), .i_protect(prot), .o_data(q), .o_data_oe(oe), .o_ready_busy(rb));
	initial begin
		forever #12.5 i_clock = ~i_clock;
	end
	// --------------------------------
	// helpers
	// --------------------------------
	function automatic fsq_pkg::fsq_sel_t pri(input int k);
		return '{4'h0, 8'h01 << k};
	endfunction
	function automatic fsq_pkg::fsq_sel_t sec(input int k);
		return '{4'h1 << k, 8'h00};
	endfunction
	task automatic w(input logic [15:0] a, input logic [7:0] d, input fsq_pkg::fsq_sel_t s);
		mcu.wr(a, a, d, s);
	endtask
	task automatic r(input logic [15:0] a, input fsq_pkg::fsq_sel_t s);
		mcu.rd(a, s, rd_q);
	endtask
	task automatic cmd(input logic [7:0] c, input fsq_pkg::fsq_sel_t s);
		w(16'hF555, 8'hAA, s);
		w(16'h0AAA, 8'h55, s);
		if (c != 8'h00) w(16'h0555, c, s);
	endtask
	task automatic wait_rb;
		int n;
		mcu.tick(3);
		for (n = 0; n < 40000 && rb !== 1'b1; n++) @(posedge i_clock);
		#2;
		`CHK("ready", 1'b1, rb)
	endtask
	task automatic t_reset;
		`CHK("ready", 1'b1, rb)
		`CHK("oe", 1'b0, oe)
		r(16'h0123, pri(0));
		`CHK("erased", 8'hFF, rd_q)
		w(16'h0123, 8'h12, pri(0));
		r(16'h0123, pri(0));
		`CHK("plain write", 8'hFF, rd_q)
		$display("test reset done");
	endtask
	task automatic t_prog;
		cmd(8'hA0, pri(1));
		mcu.wr(16'h0124, 16'h0200, 8'h3C, pri(1));
		mcu.tick(2);
		`CHK("busy", 1'b0, rb)
		r(16'h0124, pri(1));
		q2 = rd_q;
		r(16'h0124, pri(1));
		`CHK("poll", 1'b1, q2[7])
		`CHK("toggle", 2'b10, {q2[6], rd_q[6]})
		i_clk_en = 1'b0;
		mcu.tick(10);
		i_clk_en = 1'b1;
		`CHK("frozen", 1'b0, rb)
		wait_rb;
		r(16'h0124, pri(1));
		`CHK("programmed", 8'h3C, rd_q)
		r(16'h0200, pri(1));
		`CHK("late addr", 8'hFF, rd_q)
		r(16'h0124, pri(0));
		`CHK("other sector", 8'hFF, rd_q)
		$display("test program done");
	endtask
	task automatic t_prot;
		cmd(8'hA0, pri(2));
		w(16'h0124, 8'h00, pri(2));
		mcu.tick(2);
		`CHK("ignored", 1'b1, rb)
		r(16'h0124, pri(2));
		`CHK("protected", 8'hFF, rd_q)
		cmd(8'h90, pri(2));
		r(16'h0001, pri(0));
		`CHK("ident", ID, rd_q)
		r(16'h0002, pri(2));
		`CHK("prot flag", 8'h01, rd_q)
		r(16'h0002, sec(1));
		`CHK("unprot flag", 8'h00, rd_q)
		prot = 12'h204;
		r(16'h0002, sec(1));
		`CHK("prot flag", 8'h01, rd_q)
		prot = 12'h004;
		w(16'h0000, 8'hF0, pri(0));
		r(16'h0001, pri(0));
		`CHK("read mode", 8'hFF, rd_q)
		$display("test protect done");
	endtask
	task automatic t_byp;
		cmd(8'h20, pri(3));
		w(16'h0000, 8'hA0, pri(3));
		w(16'h0300, 8'h81, pri(3));
		wait_rb;
		r(16'h0300, pri(3));
		`CHK("bypass", 8'h81, rd_q)
		w(16'h0000, 8'h90, pri(3));
		w(16'h0000, 8'h00, pri(3));
		w(16'h0000, 8'hA0, pri(3));
		w(16'h0302, 8'h18, pri(3));
		r(16'h0302, pri(3));
		`CHK("bypass exit", 8'hFF, rd_q)
		$display("test bypass done");
	endtask
	task automatic t_bad;
		cmd(8'h00, '0);
		w(16'h0555, 8'hA0, pri(4));
		w(16'h0400, 8'h11, pri(4));
		cmd(8'h77, pri(4));
		w(16'h0555, 8'hA0, pri(4));
		w(16'h0402, 8'h11, pri(4));
		cmd(8'h00, pri(4));
		// gap past the command timeout
		mcu.tick(4100);
		w(16'h0555, 8'hA0, pri(4));
		w(16'h0404, 8'h11, pri(4));
		cmd(8'hA0, pri(4));
		w(16'h0406, 8'h11, pri(4));
		wait_rb;
		for (int i = 0; i < 4; i++) begin
			r(16'h0400 + 16'(2 * i), pri(4));
			`CHK("abort", (i == 3) ? 8'h11 : 8'hFF, rd_q)
		end
		$display("test abort done");
	endtask
	task automatic t_erase;
		cmd(8'hA0, sec(1));
		w(16'h0010, 8'h00, sec(1));
		wait_rb;
		cmd(8'hA0, sec(3));
		w(16'h0010, 8'h00, sec(3));
		wait_rb;
		cmd(8'h80, sec(1));
		cmd(8'h00, sec(1));
		w(16'h0010, 8'h30, sec(1));
		w(16'h0010, 8'h30, sec(3));
		mcu.tick(2);
		`CHK("erasing", 1'b0, rb)
		w(16'h0002, 8'hB0, sec(2));
		mcu.tick(2);
		`CHK("suspend", 1'b1, rb)
		r(16'h0010, sec(1));
		`CHK("susp read", 8'h00, rd_q)
		cmd(8'hA0, sec(0));
		w(16'h0020, 8'h5A, sec(0));
		wait_rb;
		w(16'h0002, 8'h30, sec(2));
		mcu.tick(2);
		`CHK("resume", 1'b0, rb)
		wait_rb;
		r(16'h0010, sec(1));
		`CHK("erased", 8'hFF, rd_q)
		r(16'h0020, sec(0));
		`CHK("susp prog", 8'h5A, rd_q)
		r(16'h0010, sec(3));
		`CHK("added", 8'hFF, rd_q)
		$display("test erase done");
	endtask
	task automatic t_bulk;
		cmd(8'hA0, sec(2));
		w(16'h0030, 8'h66, sec(2));
		wait_rb;
		prot = 12'hE04;
		cmd(8'h80, sec(3));
		cmd(8'h10, sec(3));
		w(16'h0002, 8'hB0, sec(3));
		mcu.tick(2);
		`CHK("no suspend", 1'b0, rb)
		wait_rb;
		r(16'h0020, sec(0));
		`CHK("bulk", 8'hFF, rd_q)
		r(16'h0030, sec(2));
		`CHK("bulk prot", 8'h66, rd_q)
		$display("test bulk done");
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		mcu.tick(16);
		i_rst_n = 1'b1;
		mcu.tick(2);
		t_reset;
		t_prog;
		t_prot;
		t_byp;
		t_bad;
		t_erase;
		t_bulk;
		conclude;
	end
	initial begin
		#2000000;
		error_cnt++;
		conclude;
	end
endmodule

`default_nettype wire

/* File: verif/fsq_mcu.sv */
`timescale 1ns/1ps
`default_nettype none

// --------------------------------
// host bus model; code runs from a bank it never commands
// --------------------------------
module fsq_mcu (
	input  wire logic            i_clock,
	input  wire logic [7:0]      i_data,
	output var fsq_pkg::fsq_bus_t o_bus,
	output var fsq_pkg::fsq_sel_t o_sel
);
	initial begin
		o_bus = fsq_pkg::BUS_IDLE;
		o_sel = '0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge i_clock);
		#2;
	endtask
	// a2 replaces the address once the fall has been taken
	task automatic wr(input logic [15:0] a, input logic [15:0] a2, input logic [7:0] d,
		input fsq_pkg::fsq_sel_t s);
		tick(1);
		o_bus.addr = a;
		o_bus.data = d;
		o_sel = s;
		tick(1);
		o_bus.wr_n = 1'b0;
		tick(4);
		o_bus.addr = a2;
		tick(4);
		o_bus.wr_n = 1'b1;
		tick(4);
		o_sel = '0;
		// released lines show the inverse so a stale byte never matches
		o_bus.data = ~d;
	endtask
	task automatic rd(input logic [15:0] a, input fsq_pkg::fsq_sel_t s, output logic [7:0] d);
		tick(1);
		o_bus.addr = a;
		o_sel = s;
		tick(1);
		o_bus.rd_n = 1'b0;
		tick(7);
		d = i_data;
		o_bus.rd_n = 1'b1;
		tick(4);
		o_sel = '0;
	endtask
endmodule

`default_nettype wire

/* File: verif/fsq_sequencer_asserts.sv */
`timescale 1ns/1ps
`default_nettype none

module fsq_sequencer_asserts (
	input  wire logic              i_clock,
	input  wire logic              i_rst_n,
	input  wire logic              i_clk_en,
	input  wire fsq_pkg::fsq_bus_t i_bus,
	input  wire fsq_pkg::fsq_sel_t i_sel,
	input  wire logic [11:0]       i_protect,
	input  wire logic [7:0]        o_data,
	input  wire logic              o_data_oe,
	input  wire logic              o_ready_busy
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	logic [3:0] wr_age;
	logic [3:0] rd_age;
	// --------------------------------
	// strobe ages, saturating at 15
	// --------------------------------
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) wr_age <= 4'hF;
		else if (!i_bus.wr_n) wr_age <= 4'h0;
		else if (wr_age != 4'hF) wr_age <= wr_age + 4'h1;
	end
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) rd_age <= 4'hF;
		else if (!i_bus.rd_n) rd_age <= 4'h0;
		else if (rd_age != 4'hF) rd_age <= rd_age + 4'h1;
	end
	sequence rd_idle; i_bus.rd_n [*4]; endsequence
	sequence no_sel; !(|i_sel) [*4]; endsequence
	sequence rd_held; (!i_bus.rd_n && (|i_sel)) [*5]; endsequence
	reset_state_a: assert property ($rose(i_rst_n) |-> o_ready_busy && !o_data_oe &&
		o_data == 8'h00) else $error("outputs not at reset values");
	oe_rise_a: assert property ($rose(o_data_oe) |-> !$past(i_bus.rd_n, 2) &&
		(|$past(i_sel, 2))) else $error("drive enable without selected read");
	freeze_hold_a: assert property (!i_clk_en |=> $stable(o_data) && $stable(o_data_oe) &&
		$stable(o_ready_busy)) else $error("outputs moved while clock enable low");
	oe_drop_a: assert property (rd_idle |-> !o_data_oe)
		else $error("drive enable after read ended");
	sel_drop_a: assert property (no_sel |-> !o_data_oe)
		else $error("drive enable with no bank selected");
	read_drive_a: assert property (rd_held |-> o_data_oe)
		else $error("no drive enable during selected read");
	busy_cause_a: assert property ($fell(o_ready_busy) |-> wr_age < 4'h8)
		else $error("busy without a command write");
	busy_hold_a: assert property ($fell(o_ready_busy) |=> !o_ready_busy [*4])
		else $error("busy dropped too early");
	data_hold_a: assert property ($changed(o_data) |-> rd_age < 4'h8)
		else $error("read byte changed without a read");
endmodule

bind fsq_sequencer fsq_sequencer_asserts chk (
	.i_clock(i_clock), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en), .i_bus(i_bus),
	.i_sel(i_sel), .i_protect(i_protect), .o_data(o_data), .o_data_oe(o_data_oe),
	.o_ready_busy(o_ready_busy));

`default_nettype wire
